// ---- aes_round_key_expand_tb.sv ----
// Self-checking bench for the AES round and key-expansion stage
`timescale 1ns/1ps
`default_nettype none
module aes_round_key_expand_tb;
  localparam int MAX_CYCLES = 2000; // Whole run needs well under 200
  logic             sys_clk, reset_n, op_valid;
  ark_pkg::ark_op_e op_code;
  logic [4:0]       round_constant_select;
  logic [63:0]      src1, src2, src3, result_data, dest_q, last;
  logic             aes_support_flag, float_state_enable_flag;
  logic             processor_float_enable_flag, float_unit_present;
  logic             result_valid, float_unit_off_exception, compat_feature_exception;
  logic [7:0]       trap_cnt_q;
  logic [31:0]      w;
  logic [7:0]       rc [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
                                8'h20, 8'h40, 8'h80, 8'h1b, 8'h36};
  logic [3:0]       fl_tab [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h6};
  int               failures, checked, cycles;

  ark_exec u_ark_exec (.sys_clk(sys_clk), .reset_n(reset_n), .op_valid(op_valid),
    .op_code(op_code), .round_constant_select(round_constant_select),
    .src1(src1), .src2(src2), .src3(src3), .aes_support_flag(aes_support_flag),
    .float_state_enable_flag(float_state_enable_flag),
    .processor_float_enable_flag(processor_float_enable_flag),
    .float_unit_present(float_unit_present), .result_valid(result_valid),
    .result_data(result_data), .float_unit_off_exception(float_unit_off_exception),
    .compat_feature_exception(compat_feature_exception));
  ark_pipe_model u_ark_pipe_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .result_valid(result_valid), .result_data(result_data),
    .float_unit_off_exception(float_unit_off_exception),
    .compat_feature_exception(compat_feature_exception),
    .dest_q(dest_q), .trap_cnt_q(trap_cnt_q));

  // Clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= MAX_CYCLES) begin
      failures++;
      test_done();
    end
  end

  task automatic cmp(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Flags default to a usable float unit with AES advertised
  task automatic issue(input ark_pkg::ark_op_e op, input logic [4:0] sel,
                       input logic [63:0] a, input logic [63:0] b, input logic [63:0] c,
                       input logic [3:0] fl = 4'hf);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= op;
    round_constant_select <= sel;
    src1 <= a;
    src2 <= b;
    src3 <= c;
    {aes_support_flag, float_state_enable_flag} <= fl[3:2];
    {processor_float_enable_flag, float_unit_present} <= fl[1:0];
  endtask

  task automatic idle();
    @(posedge sys_clk);
    op_valid <= 1'b0;
  endtask

  // Outcome of the op taken at the edge just passed: 0 result, 1 float off, 2 compat, 3 none
  task automatic look(input int kind, input logic [63:0] exp);
    #1;
    cmp({63'h0, result_valid}, {63'h0, kind == 0}, "result_valid");
    cmp({63'h0, float_unit_off_exception}, {63'h0, kind == 1}, "float_off");
    cmp({63'h0, compat_feature_exception}, {63'h0, kind == 2}, "compat");
    cmp(result_data, exp, "result_data");
  endtask

  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {sys_clk, reset_n, op_valid, round_constant_select} = '0;
    {src1, src2, src3} = '0;
    op_code = ark_pkg::ENCRYPT_ROUND_LOW_HALF;
    {aes_support_flag, float_state_enable_flag} = 2'h3;
    {processor_float_enable_flag, float_unit_present} = 2'h3;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    look(3, 64'h0);
    $display("test reset done");
    // Back-to-back halves of one encryption round
    issue(ark_pkg::ENCRYPT_ROUND_LOW_HALF, 5'h0, 64'h23a339392a6c7605,
          64'h193de3bea0f4e22b, 64'h9ac68d2ae9f84808);
    issue(ark_pkg::ENCRYPT_ROUND_HIGH_HALF, 5'h0, 64'ha0fafe1788542cb1,
          64'h193de3bea0f4e22b, 64'h9ac68d2ae9f84808);
    look(0, 64'h6b5bea43026a5049);
    idle();
    look(0, 64'ha49c7ff2689f352b);
    $display("test encrypt done");
    // Key XOR lands before the inverse mix
    issue(ark_pkg::DECRYPT_ROUND_LOW_HALF, 5'h0, 64'h9ac68d2ae9f84808 ^ 64'h046681e5e0cb199a,
          64'hd4bf5d30e0b452ae, 64'hb84111f11e2798e5);
    idle();
    look(0, 64'hd4bf5d30e0b452ae);
    $display("test decrypt done");
    // First two expansion steps of a 128-bit key, chained; src3 must not matter
    issue(ark_pkg::KEY_STEP_WITH_ROUND_CONSTANT, 5'h0, 64'h2b7e151628aed2a6,
          64'habf7158809cf4f3c, 64'hffffffffffffffff);
    issue(ark_pkg::KEY_STEP_PLAIN_XOR, 5'h0, 64'habf7158809cf4f3c,
          64'ha0fafe1788542cb1, 64'h5555555555555555);
    look(0, 64'ha0fafe1788542cb1);
    idle();
    look(0, 64'h23a339392a6c7605);
    $display("test key_chain done");
    // Every round constant used by a 128-bit expansion
    for (int i = 0; i < 10; i++) begin
      issue(ark_pkg::KEY_STEP_WITH_ROUND_CONSTANT, i[4:0], 64'h0, 64'h0, 64'h0);
      idle();
      w = 32'h63636363 ^ {rc[i], 24'h0};
      look(0, {w, w});
    end
    $display("test round_constant done");
    // Substitution with no rotation: a rotated word would differ
    issue(ark_pkg::KEY_STEP_SUBSTITUTE_ONLY, 5'h0, 64'h1111111122222222,
          64'hdeadbeef00000001, 64'h0);
    idle();
    last = {32'h7272726d, 32'h7272726d ^ 32'h22222222};
    look(0, last);
    $display("test substitute done");
    // Each disabling flag alone, then both causes together
    for (int j = 0; j < 5; j++) begin
      issue(ark_pkg::KEY_STEP_PLAIN_XOR, 5'h0, 64'h0, 64'h1, 64'h0, fl_tab[j]);
      idle();
      look((fl_tab[j][2:0] != 3'h7) ? 1 : 2, last);
    end
    $display("test refused done");
    issue(ark_pkg::ark_op_e'(3'h6), 5'h0, 64'h1, 64'h1, 64'h1);
    idle();
    look(3, last);
    $display("test invalid_code done");
    cmp(dest_q, last, "dest");
    cmp({56'h0, trap_cnt_q}, 64'h5, "traps");
    $display("test writeback done");
    // Mid-run reset clears both sides; first op right after release is taken
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    look(3, 64'h0);
    cmp(dest_q, 64'h0, "dest after reset");
    issue(ark_pkg::KEY_STEP_PLAIN_XOR, 5'h0, 64'h0, 64'h0000000089abcdef, 64'h0);
    idle();
    look(0, 64'h89abcdef89abcdef);
    $display("test mid_reset done");
    test_done();
  end
endmodule
`default_nettype wire

// ---- ark_exec.sv ----
// AES round and key-expansion execution stage, one result per issued op with a defined code and no exception
`timescale 1ns/1ps
`default_nettype none
module ark_exec (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             op_valid,
  input  wire ark_pkg::ark_op_e op_code,
  input  wire logic [4:0]       round_constant_select,
  input  wire logic [63:0]      src1,
  input  wire logic [63:0]      src2,
  input  wire logic [63:0]      src3,
  input  wire logic             aes_support_flag,
  input  wire logic             float_state_enable_flag,
  input  wire logic             processor_float_enable_flag,
  input  wire logic             float_unit_present,
  output logic                  result_valid,
  output logic      [63:0]      result_data,
  output logic                  float_unit_off_exception,
  output logic                  compat_feature_exception
);

  // ------------------------------------------------------------------
  // State assembly and byte substitution
  // ------------------------------------------------------------------
  logic         is_dec;
  logic         is_key;
  logic [127:0] state_in;
  logic [127:0] sb_st;
  logic [127:0] sr_st;
  logic [127:0] isr_st;
  logic [127:0] mc_st;
  logic [63:0]  dec_ark;
  logic [63:0]  dec_out;
  logic [31:0]  key_sb;
  logic [31:0]  key_rot_sb;
  logic [31:0]  key_word;
  logic [63:0]  key_out;
  logic [63:0]  exec_d;
  logic         fp_off;
  logic         take_fp_off;
  logic         take_compat;
  logic         write_d;

  assign is_dec = (op_code == ark_pkg::DECRYPT_ROUND_LOW_HALF);
  assign is_key = (op_code == ark_pkg::KEY_STEP_SUBSTITUTE_ONLY) ||
                  (op_code == ark_pkg::KEY_STEP_WITH_ROUND_CONSTANT) ||
                  (op_code == ark_pkg::KEY_STEP_PLAIN_XOR);

  // Key steps place source two's low word where the low state word sits
  assign state_in = is_key ? {src3, src2} : {src2, src3};

  // Substitution is bytewise, so it commutes with the row permutation;
  // one cell array serves both directions and the key steps.
  genvar gi;
  generate
    for (gi = 0; gi < ark_pkg::ARK_STATE_BYTES; gi++) begin : g_byte
      localparam int ROW = gi % ark_pkg::ARK_ROWS;
      localparam int COL = gi / ark_pkg::ARK_ROWS;
      localparam int FWD = ROW + 4 * ((COL + ROW) % 4);
      localparam int INV = ROW + 4 * ((COL + 4 - ROW) % 4);
      ark_sbox u_sbox (
        .byte_in  (state_in[127 - 8 * gi -: 8]),
        .inverse  (is_dec),
        .byte_out (sb_st[127 - 8 * gi -: 8])
      );
      // Row shift forward and inverse, byte 0 at the top
      assign sr_st[127 - 8 * gi -: 8]  = sb_st[127 - 8 * FWD -: 8];
      assign isr_st[127 - 8 * gi -: 8] = sb_st[127 - 8 * INV -: 8];
    end
    for (gi = 0; gi < ark_pkg::ARK_ROWS; gi++) begin : g_col
      assign mc_st[127 - 32 * gi -: 32] = ark_pkg::ark_mix_col(sr_st[127 - 32 * gi -: 32]);
    end
  endgenerate

  // ------------------------------------------------------------------
  // Decryption tail and key-expansion words
  // ------------------------------------------------------------------
  assign dec_ark = isr_st[63:0] ^ src1;
  assign dec_out = {ark_pkg::ark_inv_mix_col(dec_ark[63:32]),
                    ark_pkg::ark_inv_mix_col(dec_ark[31:0])};

  assign key_sb     = sb_st[31:0];
  assign key_rot_sb = {key_sb[23:0], key_sb[31:24]};

  // Transformed word per key step; only substitution, rotation, XOR
  always_comb begin
    case (op_code)
      ark_pkg::KEY_STEP_SUBSTITUTE_ONLY:     key_word = key_sb;
      ark_pkg::KEY_STEP_WITH_ROUND_CONSTANT:
        key_word = key_rot_sb ^ ark_pkg::ark_rcon(round_constant_select);
      default:                               key_word = src2[31:0];
    endcase
  end

  // Lower word chains in source one's lower word as well
  assign key_out = {key_word ^ src1[63:32], key_word ^ src1[63:32] ^ src1[31:0]};

  // Result select per operation
  always_comb begin
    case (op_code)
      ark_pkg::ENCRYPT_ROUND_LOW_HALF:  exec_d = mc_st[63:0] ^ src1;
      ark_pkg::ENCRYPT_ROUND_HIGH_HALF: exec_d = mc_st[127:64] ^ src1;
      ark_pkg::DECRYPT_ROUND_LOW_HALF:  exec_d = dec_out;
      ark_pkg::KEY_STEP_SUBSTITUTE_ONLY,
      ark_pkg::KEY_STEP_WITH_ROUND_CONSTANT,
      ark_pkg::KEY_STEP_PLAIN_XOR:      exec_d = key_out;
      default:                          exec_d = ark_pkg::ARK_DWORD_ZERO;
    endcase
  end

  // ------------------------------------------------------------------
  // Exception screening
  // ------------------------------------------------------------------
  // Float-off outranks the feature check, matching trap priority order
  assign fp_off      = !float_unit_present || !float_state_enable_flag ||
                       !processor_float_enable_flag;
  assign take_fp_off = op_valid && fp_off;
  assign take_compat = op_valid && !fp_off && !aes_support_flag;
  assign write_d     = op_valid && !fp_off && aes_support_flag &&
                       (is_key || is_dec || (op_code == ark_pkg::ENCRYPT_ROUND_LOW_HALF) ||
                        (op_code == ark_pkg::ENCRYPT_ROUND_HIGH_HALF));

  // Result stage; data holds when nothing is written
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_valid <= 1'b0;
      result_data  <= ark_pkg::ARK_DWORD_ZERO;
    end else begin
      result_valid <= write_d;
      if (write_d) result_data <= exec_d;
    end
  end

  // Exception pulses, one cycle per refused op
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      float_unit_off_exception <= 1'b0;
      compat_feature_exception <= 1'b0;
    end else begin
      float_unit_off_exception <= take_fp_off;
      compat_feature_exception <= take_compat;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic ok_in;
  assign ok_in = op_valid && !fp_off && aes_support_flag;

  a_compat_no_result: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (op_valid && !fp_off && !aes_support_flag) |=> (compat_feature_exception && !result_valid))
    else $error("compat exception missing or result written");

  a_fp_off_trap: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (op_valid && fp_off) |=> (float_unit_off_exception && !compat_feature_exception
                              && !result_valid))
    else $error("float-off exception not taken alone");

  a_one_outcome: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $onehot0({result_valid, float_unit_off_exception, compat_feature_exception}))
    else $error("more than one outcome for an op");

  a_enc_low_key: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ok_in && op_code == ark_pkg::ENCRYPT_ROUND_LOW_HALF)
    |=> result_data == ($past(mc_st[63:0]) ^ $past(src1)))
    else $error("low encryption half wrong");

  a_enc_high_key: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ok_in && op_code == ark_pkg::ENCRYPT_ROUND_HIGH_HALF)
    |=> result_data == ($past(mc_st[127:64]) ^ $past(src1)))
    else $error("high encryption half wrong");

  a_plain_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ok_in && op_code == ark_pkg::KEY_STEP_PLAIN_XOR)
    |=> (result_data[63:32] == ($past(src2[31:0]) ^ $past(src1[63:32])) &&
         result_data[31:0] == (result_data[63:32] ^ $past(src1[31:0]))))
    else $error("plain key step wrong");

  a_rcon_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ok_in && op_code == ark_pkg::KEY_STEP_WITH_ROUND_CONSTANT && round_constant_select == 5'h0)
    |=> (result_data[63:32] == ($past(key_rot_sb) ^ 32'h01000000 ^ $past(src1[63:32]))))
    else $error("round constant step wrong");

  a_result_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !write_d |=> $stable(result_data))
    else $error("result changed without a write");

  // Codes past the last defined op never write a result, so they are left out here
  a_valid_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ok_in && op_code <= ark_pkg::KEY_STEP_PLAIN_XOR) |=> result_valid)
    else $error("result not produced one cycle after issue");

endmodule
`default_nettype wire

// ---- ark_pipe_model.sv ----
// Write-back side of the issuing pipeline: destination register and trap count
`timescale 1ns/1ps
`default_nettype none
module ark_pipe_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        result_valid,
  input  wire logic [63:0] result_data,
  input  wire logic        float_unit_off_exception,
  input  wire logic        compat_feature_exception,
  output logic      [63:0] dest_q,
  output logic      [7:0]  trap_cnt_q
);
  // Destination keeps the last written word, so expanded keys can be reused
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dest_q <= 64'h0;
    end else if (result_valid) begin
      dest_q <= result_data;
    end
  end
  // Traps taken; a refused op must never reach the destination
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_cnt_q <= 8'h0;
    end else if (float_unit_off_exception || compat_feature_exception) begin
      trap_cnt_q <= trap_cnt_q + 8'h1;
    end
  end
endmodule
`default_nettype wire

// ---- ark_pkg.sv ----
// Constants, types and field arithmetic shared by the AES execution block
// Summary of operation
// - Encryption rounds run byte substitution, row shifting, column mixing, then key XOR.
// - The low encryption half mixes the state formed from source two and three, XORs the low 64 bits with source one.
// - The high encryption half takes the upper 64 mixed bits XORed with source one.
// - The low decryption half inverse-shifts, inverse-substitutes, XORs source one, then inverse-mixes the 64 bits.
// - Key steps use only byte substitution, word rotation and XOR.
// - The round-constant key step XORs an immediate-selected constant into both result words.
// - The substitute-only step XORs the substituted low word of source two with source one's words; the plain step XORs source two's low word unchanged.
// - With the AES support flag clear and the float unit usable, an AES op raises the compatibility exception and writes no result.
package ark_pkg;

  // ------------------------------------------------------------------
  // Operation codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ENCRYPT_ROUND_LOW_HALF,
    ENCRYPT_ROUND_HIGH_HALF,
    DECRYPT_ROUND_LOW_HALF,
    KEY_STEP_SUBSTITUTE_ONLY,
    KEY_STEP_WITH_ROUND_CONSTANT,
    KEY_STEP_PLAIN_XOR
  } ark_op_e;

  // ------------------------------------------------------------------
  // Field constants
  // ------------------------------------------------------------------
  localparam int          ARK_BYTE_BITS  = 8;
  localparam int          ARK_STATE_BYTES = 16;
  localparam int          ARK_ROWS       = 4;
  localparam int          ARK_RCON_STEPS = 32;
  localparam logic [7:0]  ARK_AFFINE_FWD = 8'h63;
  localparam logic [7:0]  ARK_AFFINE_INV = 8'h05;
  localparam logic [7:0]  ARK_POLY_RED   = 8'h1b;
  localparam logic [7:0]  ARK_RCON_SEED  = 8'h01;
  localparam logic [7:0]  ARK_BYTE_ZERO  = 8'h00;
  localparam logic [63:0] ARK_DWORD_ZERO = 64'h0;
  localparam logic [23:0] ARK_RCON_PAD   = 24'h0;

  // Multiply by x in the field
  function automatic logic [7:0] ark_xtime(input logic [7:0] a);
    ark_xtime = {a[6:0], 1'b0} ^ (a[7] ? ARK_POLY_RED : ARK_BYTE_ZERO);
  endfunction

  // Shift-and-add field multiply
  function automatic logic [7:0] ark_gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] p;
    acc = ARK_BYTE_ZERO;
    p   = a;
    for (int i = 0; i < ARK_BYTE_BITS; i++) begin
      if (b[i]) acc = acc ^ p;
      p = ark_xtime(p);
    end
    ark_gmul = acc;
  endfunction

  // Inverse as a to the 254th; zero maps to zero
  function automatic logic [7:0] ark_ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] p;
    r = ARK_RCON_SEED;
    p = a;
    for (int i = 1; i < ARK_BYTE_BITS; i++) begin
      p = ark_gmul(p, p);
      r = ark_gmul(r, p);
    end
    ark_ginv = r;
  endfunction

  // Round constant: x to the power of the selector, in the top byte
  function automatic logic [31:0] ark_rcon(input logic [4:0] sel);
    logic [7:0] v;
    v = ARK_RCON_SEED;
    for (int i = 0; i < ARK_RCON_STEPS; i++) begin
      if (i < int'(sel)) v = ark_xtime(v);
    end
    ark_rcon = {v, ARK_RCON_PAD};
  endfunction

  // Forward column mix on one 32-bit column, top byte is row 0
  function automatic logic [31:0] ark_mix_col(input logic [31:0] c);
    logic [7:0] a0, a1, a2, a3;
    a0 = c[31:24];
    a1 = c[23:16];
    a2 = c[15:8];
    a3 = c[7:0];
    ark_mix_col = {ark_xtime(a0) ^ ark_xtime(a1) ^ a1 ^ a2 ^ a3,
                   a0 ^ ark_xtime(a1) ^ ark_xtime(a2) ^ a2 ^ a3,
                   a0 ^ a1 ^ ark_xtime(a2) ^ ark_xtime(a3) ^ a3,
                   ark_xtime(a0) ^ a0 ^ a1 ^ a2 ^ ark_xtime(a3)};
  endfunction

  // Inverse column mix with the 0e/0b/0d/09 matrix
  function automatic logic [31:0] ark_inv_mix_col(input logic [31:0] c);
    logic [7:0] a0, a1, a2, a3;
    a0 = c[31:24];
    a1 = c[23:16];
    a2 = c[15:8];
    a3 = c[7:0];
    ark_inv_mix_col = {
      ark_gmul(a0, 8'h0e) ^ ark_gmul(a1, 8'h0b) ^ ark_gmul(a2, 8'h0d) ^ ark_gmul(a3, 8'h09),
      ark_gmul(a0, 8'h09) ^ ark_gmul(a1, 8'h0e) ^ ark_gmul(a2, 8'h0b) ^ ark_gmul(a3, 8'h0d),
      ark_gmul(a0, 8'h0d) ^ ark_gmul(a1, 8'h09) ^ ark_gmul(a2, 8'h0e) ^ ark_gmul(a3, 8'h0b),
      ark_gmul(a0, 8'h0b) ^ ark_gmul(a1, 8'h0d) ^ ark_gmul(a2, 8'h09) ^ ark_gmul(a3, 8'h0e)};
  endfunction

endpackage

// ---- ark_sbox.sv ----
// One byte substitution cell, forward or inverse
`timescale 1ns/1ps
`default_nettype none
module ark_sbox (
  input  wire logic [7:0] byte_in,
  input  wire logic       inverse,
  output logic      [7:0] byte_out
);

  logic [7:0] pre;
  logic [7:0] inv_v;
  logic [7:0] fwd;

  // Inverse direction undoes the affine map before the field inverse
  always_comb begin
    for (int i = 0; i < ark_pkg::ARK_BYTE_BITS; i++) begin
      pre[i] = byte_in[(i + 2) % 8] ^ byte_in[(i + 5) % 8] ^ byte_in[(i + 7) % 8]
               ^ ark_pkg::ARK_AFFINE_INV[i];
    end
  end

  assign inv_v = ark_pkg::ark_ginv(inverse ? pre : byte_in);

  // Forward affine map after the field inverse
  always_comb begin
    for (int i = 0; i < ark_pkg::ARK_BYTE_BITS; i++) begin
      fwd[i] = inv_v[i] ^ inv_v[(i + 4) % 8] ^ inv_v[(i + 5) % 8] ^ inv_v[(i + 6) % 8]
               ^ inv_v[(i + 7) % 8] ^ ark_pkg::ARK_AFFINE_FWD[i];
    end
  end

  assign byte_out = inverse ? inv_v : fwd;

endmodule
`default_nettype wire
